// file: src/btb_bitop.sv
// Bit test with clear or complement, and carry capture
`timescale 1ns/1ps
`include "btb_defines.svh"
module btb_bitop import btb_pkg::*; (
    // Operand
    input wire logic [23:0] word,
    input wire logic [4:0] bitn,
    input wire logic toggle,
    input wire logic sr_dest,
    input wire logic [23:0] sr,
    // Results
    output logic [23:0] new_word,
    output logic [23:0] new_sr
);
    logic carry;

    genvar i;
    generate
        for (i = 0; i < 24; i++) begin : g_bit
            assign new_word[i] = (bitn == 5'(i)) ?
                (toggle & ~word[i]) : word[i]; // RULE1
        end
    endgenerate

    assign carry = word[bitn]; // RULE1
    // Status word as target: only the chosen bit moves, carry is not forced
    assign new_sr = sr_dest ? new_word :
        {sr[23:1], carry}; // RULE5 RULE6 RULE7 RULE8
endmodule : btb_bitop

// file: src/btb_core.sv
// Bit-test-and-clear/change and branch-always execution unit
// Overview of operation
// RULE1: Carry takes tested bit; bit cleared, written back
// RULE2: Bit position immediate, valid zero to twenty-three
// RULE3: Memory clear is locked read then write
// RULE4: Full accumulators refused; their parts allowed
// RULE5: Status target 0-7 clears that flag only
// RULE6: Status target 8-15 alters one mode bit
// RULE7: Other targets: carry equals tested bit
// RULE8: Other targets: remaining flags unchanged
// RULE9: Absolute short reaches lowest sixty-four words
// RULE10: Upper peripheral short starts at ffffc0
// RULE11: Lower peripheral short starts at ffff80
// RULE12: Change opcode: 0b, mode bits, 0 S 0
// RULE13: Change lower peripheral and register encodings
// RULE14: Clear opcode: 0a, mode bits, 0 S 0
// RULE15: Clear lower peripheral and register encodings
// RULE16: Long branch adds 24-bit extension word
// RULE17: Short branch sign-extends nine-bit field
// RULE18: Pointer branch adds one of eight pointers
// RULE19: Branch leaves condition flags untouched
// RULE20: Bit number is five bits, 4..0
// RULE21: Space bit six: zero X, one Y
`timescale 1ns/1ps
`include "btb_defines.svh"
module btb_core import btb_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Data memory bus
    output btb_mem_s mem_cmd,
    input wire logic mem_ack,
    input wire logic [23:0] mem_rdata,
    // Core register file
    output btb_reg_s reg_cmd,
    input wire logic [23:0] reg_rdata
);
    btb_state_e state_ff;
    btb_dec_s dec;
    btb_mem_s mem_cmd_ff;
    btb_reg_s reg_cmd_ff;
    logic [23:0] instr_ff;
    logic [23:0] ext_ff;
    logic [23:0] pc_ff;
    logic [23:0] sr_ff;
    logic [23:0] ptr_ff [8];
    logic illegal_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] rd_val;
    logic [23:0] op_word;
    logic [23:0] new_word;
    logic [23:0] new_sr;
    logic [23:0] eff_addr;
    logic [23:0] short_ext;
    logic [23:0] pc_step;
    logic setup;
    logic access;
    logic hit;
    logic busy;
    logic wr;
    logic start;
    logic sr_target;

    assign busy = (state_ff != BTB_IDLE);
    assign setup = psel & ~penable;
    assign access = psel & penable & pready_ff;
    assign wr = access & pwrite & ~pslverr_ff;
    assign start = wr && paddr == `BTB_OFF_INSTR;
    assign sr_target = dec.form == BTB_F_REG &&
        dec.field == `BTB_REG_STAT_WORD;

    btb_decode u_decode (
        .instr(instr_ff),
        .dec(dec)
    );

    // One bit engine, fed from whichever source is being modified
    always_comb begin
        case (state_ff)
            BTB_MEM_RD: op_word = mem_rdata;
            BTB_REG_RD: op_word = reg_rdata;
            default: op_word = sr_ff;
        endcase
    end

    btb_bitop u_bitop (
        .word(op_word),
        .bitn(dec.bitn),
        .toggle(dec.toggle),
        .sr_dest(state_ff == BTB_EXEC),
        .sr(sr_ff),
        .new_word(new_word),
        .new_sr(new_sr)
    );

    always_comb begin
        case (dec.form)
            BTB_F_EA: eff_addr = (dec.field == `BTB_EA_ABS) ? ext_ff :
                ptr_ff[dec.field[2:0]];
            BTB_F_ABS: eff_addr = {18'h00000, dec.field}; // RULE9
            BTB_F_PP: eff_addr = `BTB_PP_BASE | {18'h00000, dec.field}; // RULE10
            BTB_F_QQ: eff_addr = `BTB_QQ_BASE | {18'h00000, dec.field}; // RULE11
            default: eff_addr = 24'h000000;
        endcase
    end

    assign short_ext = {{15{dec.short_disp[8]}}, dec.short_disp}; // RULE17
    assign pc_step = (dec.form == BTB_F_EA && dec.field == `BTB_EA_ABS) ?
        24'h000002 : 24'h000001;

    // APB slave: zero wait states, answer prepared in the setup cycle
    always_comb begin
        hit = 1'b1;
        case (paddr)
            `BTB_OFF_INSTR: rd_val = {8'h00, instr_ff};
            `BTB_OFF_EXT: rd_val = {8'h00, ext_ff};
            `BTB_OFF_PC: rd_val = {8'h00, pc_ff};
            `BTB_OFF_STAT_WORD: rd_val = {8'h00, sr_ff};
            `BTB_OFF_STATE: rd_val = {30'h00000000, illegal_ff, busy};
            default: begin
                hit = paddr[7:5] == `BTB_PTR_REGION && paddr[1:0] == 2'b00;
                rd_val = hit ? {8'h00, ptr_ff[paddr[4:2]]} : 32'h00000000;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= setup;
            // Writes during execution would race the engine, so refuse
            pslverr_ff <= setup & (~hit | (pwrite & busy));
            prdata_ff <= (setup & ~pwrite & hit) ? rd_val : 32'h00000000;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            instr_ff <= 24'h000000;
            ext_ff <= 24'h000000;
        end else if (wr) begin
            if (paddr == `BTB_OFF_INSTR) begin
                instr_ff <= pwdata[23:0];
            end
            if (paddr == `BTB_OFF_EXT) begin
                ext_ff <= pwdata[23:0];
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_ptr
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    ptr_ff[gi] <= `BTB_RST_PTR;
                end else if (wr && paddr[7:5] == `BTB_PTR_REGION &&
                             paddr[4:2] == 3'(gi)) begin
                    ptr_ff[gi] <= pwdata[23:0];
                end
            end
        end
    endgenerate

    // Sequencer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= BTB_IDLE;
            illegal_ff <= 1'b0;
        end else begin
            case (state_ff)
                BTB_IDLE: begin
                    if (start) begin
                        state_ff <= BTB_EXEC;
                        illegal_ff <= 1'b0;
                    end
                end
                BTB_EXEC: begin
                    if (dec.illegal) begin
                        state_ff <= BTB_IDLE; // RULE2 RULE4
                        illegal_ff <= 1'b1;
                    end else if (dec.form inside {BTB_F_EA, BTB_F_ABS,
                                                  BTB_F_PP, BTB_F_QQ}) begin
                        state_ff <= BTB_MEM_RD;
                    end else if (dec.form == BTB_F_REG && !sr_target) begin
                        state_ff <= BTB_REG_RD;
                    end else begin
                        state_ff <= BTB_IDLE;
                    end
                end
                BTB_MEM_RD: begin
                    if (mem_ack) begin
                        state_ff <= BTB_MEM_WR;
                    end
                end
                BTB_MEM_WR: begin
                    if (mem_ack) begin
                        state_ff <= BTB_IDLE;
                    end
                end
                BTB_REG_RD: state_ff <= BTB_REG_WR;
                BTB_REG_WR: state_ff <= BTB_IDLE;
                default: state_ff <= BTB_IDLE;
            endcase
        end
    end

    // Memory side: lock stays up from the read until the write is taken
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_cmd_ff <= '0;
        end else if (state_ff == BTB_EXEC && !dec.illegal &&
                     dec.form inside {BTB_F_EA, BTB_F_ABS,
                                      BTB_F_PP, BTB_F_QQ}) begin
            mem_cmd_ff.req <= 1'b1; // RULE3
            mem_cmd_ff.we <= 1'b0;
            mem_cmd_ff.lock <= 1'b1;
            mem_cmd_ff.space <= dec.space; // RULE21
            mem_cmd_ff.addr <= eff_addr;
        end else if (state_ff == BTB_MEM_RD && mem_ack) begin
            mem_cmd_ff.we <= 1'b1; // RULE3
            mem_cmd_ff.wdata <= new_word; // RULE1
        end else if (state_ff == BTB_MEM_WR && mem_ack) begin
            mem_cmd_ff.req <= 1'b0;
            mem_cmd_ff.we <= 1'b0;
            mem_cmd_ff.lock <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_cmd_ff <= '0;
        end else if (state_ff == BTB_EXEC && !dec.illegal &&
                     dec.form == BTB_F_REG && !sr_target) begin
            reg_cmd_ff.sel <= 1'b1; // RULE4
            reg_cmd_ff.idx <= dec.field;
        end else if (state_ff == BTB_REG_RD) begin
            reg_cmd_ff.we <= 1'b1;
            reg_cmd_ff.wdata <= new_word; // RULE1
        end else if (state_ff == BTB_REG_WR) begin
            reg_cmd_ff <= '0;
        end
    end

    // Status word: carry capture, or single-bit edit when it is the target
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sr_ff <= `BTB_RST_STAT_WORD;
        end else if (wr && paddr == `BTB_OFF_STAT_WORD) begin
            sr_ff <= pwdata[23:0];
        end else if (state_ff == BTB_EXEC && !dec.illegal && sr_target) begin
            sr_ff <= new_sr; // RULE5 RULE6
        end else if ((state_ff == BTB_MEM_RD && mem_ack) ||
                     state_ff == BTB_REG_RD) begin
            sr_ff <= new_sr; // RULE7 RULE8
        end
    end

    // Program counter; branches never touch the status word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pc_ff <= `BTB_RST_PC;
        end else if (wr && paddr == `BTB_OFF_PC) begin
            pc_ff <= pwdata[23:0];
        end else if (state_ff == BTB_EXEC && !dec.illegal) begin
            case (dec.form)
                BTB_F_BRA_LONG: pc_ff <= pc_ff + ext_ff; // RULE16 RULE19
                BTB_F_BRA_SHORT: pc_ff <= pc_ff + short_ext; // RULE17
                BTB_F_BRA_PTR: pc_ff <= pc_ff + ptr_ff[dec.ptr]; // RULE18
                BTB_F_REG: pc_ff <= sr_target ? pc_ff + pc_step : pc_ff;
                default: pc_ff <= pc_ff;
            endcase
        end else if ((state_ff == BTB_MEM_WR && mem_ack) ||
                     state_ff == BTB_REG_WR) begin
            pc_ff <= pc_ff + pc_step;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mem_cmd = mem_cmd_ff;
    assign reg_cmd = reg_cmd_ff;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    logic exp_carry;
    logic [23:0] exp_target;
    assign exp_carry = mem_rdata[dec.bitn];
    assign exp_target = ptr_ff[dec.ptr];

    a_rmw_locked: assert property ( // RULE3
        (state_ff == BTB_MEM_RD && mem_ack) |=>
            mem_cmd.lock && mem_cmd.req && mem_cmd.we)
        else $error("bus lock dropped between read and write");
    a_carry_capture: assert property ( // RULE7
        (state_ff == BTB_MEM_RD && mem_ack) |=>
            sr_ff[`BTB_CARRY_BIT] == $past(exp_carry))
        else $error("carry does not hold the tested bit");
    a_clear_write: assert property ( // RULE1
        (state_ff == BTB_MEM_RD && mem_ack && !dec.toggle) |=>
            !mem_cmd.wdata[dec.bitn])
        else $error("tested bit not cleared in write data");
    a_flags_kept: assert property ( // RULE8
        (state_ff == BTB_MEM_RD && mem_ack) |=>
            sr_ff[23:1] == $past(sr_ff[23:1]))
        else $error("flags other than carry changed");
    a_sr_one_bit: assert property ( // RULE5
        (state_ff == BTB_EXEC && sr_target && !dec.illegal) |=>
            $countones(sr_ff ^ $past(sr_ff)) <= 1)
        else $error("status target changed more than one bit");
    a_acc_refused: assert property ( // RULE4
        (state_ff == BTB_EXEC && dec.form == BTB_F_REG &&
         dec.field == `BTB_REG_ACC_A) |=>
            illegal_ff && state_ff == BTB_IDLE && !reg_cmd.sel)
        else $error("full accumulator accepted as target");
    a_bit_range: assert property ( // RULE2
        (state_ff == BTB_EXEC && dec.form == BTB_F_ABS &&
         dec.bitn > `BTB_BIT_MAX) |=> illegal_ff && !mem_cmd.req)
        else $error("bit position above 23 accepted");
    a_pp_addr: assert property ( // RULE10
        (state_ff == BTB_EXEC && dec.form == BTB_F_PP && !dec.illegal) |=>
            mem_cmd.addr == (`BTB_PP_BASE | {18'h00000, $past(dec.field)}))
        else $error("upper peripheral address wrong");
    a_qq_addr: assert property ( // RULE11
        (state_ff == BTB_EXEC && dec.form == BTB_F_QQ && !dec.illegal) |=>
            mem_cmd.addr == (`BTB_QQ_BASE | {18'h00000, $past(dec.field)}))
        else $error("lower peripheral address wrong");
    a_abs_addr: assert property ( // RULE9
        (state_ff == BTB_EXEC && dec.form == BTB_F_ABS && !dec.illegal) |=>
            mem_cmd.addr[23:6] == 18'h00000 &&
            mem_cmd.space == $past(instr_ff[6]))
        else $error("absolute short address or space wrong");
    a_bra_short: assert property ( // RULE17
        (state_ff == BTB_EXEC && dec.form == BTB_F_BRA_SHORT) |=>
            pc_ff == $past(pc_ff) + $past(short_ext))
        else $error("short branch target wrong");
    a_bra_long: assert property ( // RULE16
        (state_ff == BTB_EXEC && dec.form == BTB_F_BRA_LONG) |=>
            pc_ff == $past(pc_ff) + $past(ext_ff))
        else $error("long branch target wrong");
    a_bra_ptr: assert property ( // RULE18
        (state_ff == BTB_EXEC && dec.form == BTB_F_BRA_PTR) |=>
            pc_ff == $past(pc_ff) + $past(exp_target))
        else $error("pointer branch target wrong");
    a_bra_flags: assert property ( // RULE19
        (state_ff == BTB_EXEC && dec.form inside {BTB_F_BRA_LONG,
         BTB_F_BRA_SHORT, BTB_F_BRA_PTR}) |=> $stable(sr_ff))
        else $error("branch altered the status word");
    a_qq_decode: assert property ( // RULE15
        (instr_ff[23:14] == 10'h004 && !instr_ff[7] && !instr_ff[5]) |->
            dec.form == BTB_F_QQ && !dec.toggle)
        else $error("lower peripheral clear misdecoded");

    c_mem_rmw: cover property (
        state_ff == BTB_MEM_WR && mem_ack);
    c_sr_edit: cover property (
        state_ff == BTB_EXEC && sr_target && !dec.illegal);
    c_bra_short: cover property (
        state_ff == BTB_EXEC && dec.form == BTB_F_BRA_SHORT);
endmodule : btb_core

// file: src/btb_decode.sv
// Instruction word decoder for bit test and unconditional branch
`timescale 1ns/1ps
`include "btb_defines.svh"
module btb_decode import btb_pkg::*; (
    // Instruction
    input wire logic [23:0] instr,
    // Decoded fields
    output btb_dec_s dec
);
    always_comb begin
        dec = '0;
        dec.form = BTB_F_NONE;
        dec.space = instr[6]; // RULE21
        dec.bitn = instr[4:0]; // RULE20
        dec.field = instr[13:8];
        dec.ptr = instr[10:8];
        dec.short_disp = {instr[9:6], instr[4:0]};
        dec.toggle = instr[16];
        if (instr[23:16] == `BTB_OP_ZERO || instr[23:16] == `BTB_OP_TOGGLE) begin
            if (instr[15:14] == `BTB_MODE_REG) begin
                if (instr[7:5] == `BTB_REG_TAIL) begin // RULE13 RULE15
                    dec.form = BTB_F_REG;
                end
            end else if (!instr[7] && !instr[5]) begin // RULE12 RULE14
                case (instr[15:14])
                    `BTB_MODE_EA: dec.form = BTB_F_EA;
                    `BTB_MODE_ABS: dec.form = BTB_F_ABS;
                    `BTB_MODE_PP: dec.form = BTB_F_PP;
                    default: dec.form = BTB_F_NONE;
                endcase
            end
        end else if (instr[23:16] == `BTB_OP_PERIPH_LO && !instr[15] &&
                     !instr[7] && !instr[5]) begin
            dec.form = BTB_F_QQ; // RULE13 RULE15
            dec.toggle = instr[14];
        end else if (instr == `BTB_BRA_LONG) begin
            dec.form = BTB_F_BRA_LONG;
        end else if (instr[23:10] == `BTB_BRA_SHORT_HI && !instr[5]) begin
            dec.form = BTB_F_BRA_SHORT;
        end else if (instr[23:11] == `BTB_BRA_PTR_HI &&
                     instr[7:0] == `BTB_BRA_PTR_LO) begin
            dec.form = BTB_F_BRA_PTR;
        end
        // Positions above 23 do not exist in a 24-bit word
        if (dec.form inside {BTB_F_EA, BTB_F_ABS, BTB_F_PP, BTB_F_QQ,
                             BTB_F_REG} && dec.bitn > `BTB_BIT_MAX) begin
            dec.illegal = 1'b1; // RULE2
        end
        if (dec.form == BTB_F_REG && (dec.field == `BTB_REG_ACC_A ||
                                      dec.field == `BTB_REG_ACC_B)) begin
            dec.illegal = 1'b1; // RULE4
        end
        // Only pointer-indirect and absolute-long effective addresses
        if (dec.form == BTB_F_EA && dec.field[5:3] != `BTB_EA_PTR &&
            dec.field != `BTB_EA_ABS) begin
            dec.illegal = 1'b1;
        end
        if (dec.form == BTB_F_NONE) begin
            dec.illegal = 1'b1;
        end
    end
endmodule : btb_decode

// file: src/btb_defines.svh
// Offsets, opcode fields, reset values and codes of the bit-test/branch unit
`ifndef BTB_DEFINES_SVH
`define BTB_DEFINES_SVH

`define BTB_OFF_INSTR 8'h00
`define BTB_OFF_EXT 8'h04
`define BTB_OFF_PC 8'h08
`define BTB_OFF_STAT_WORD 8'h0c
`define BTB_OFF_STATE 8'h10
`define BTB_PTR_REGION 3'b001
`define BTB_RST_PC 24'h000000
`define BTB_RST_STAT_WORD 24'h000000
`define BTB_RST_PTR 24'h000000
`define BTB_OP_ZERO 8'h0a
`define BTB_OP_TOGGLE 8'h0b
`define BTB_OP_PERIPH_LO 8'h01
`define BTB_MODE_EA 2'b01
`define BTB_MODE_ABS 2'b00
`define BTB_MODE_PP 2'b10
`define BTB_MODE_REG 2'b11
`define BTB_REG_TAIL 3'b010
`define BTB_BRA_LONG 24'h0d10c0
`define BTB_BRA_SHORT_HI 14'h0143
`define BTB_BRA_PTR_HI 13'h01a3
`define BTB_BRA_PTR_LO 8'hc0
`define BTB_PP_BASE 24'hffffc0
`define BTB_QQ_BASE 24'hffff80
`define BTB_BIT_MAX 5'h17
`define BTB_EA_ABS 6'h30
`define BTB_EA_PTR 3'h4
`define BTB_REG_STAT_WORD 6'h39
`define BTB_REG_ACC_A 6'h0e
`define BTB_REG_ACC_B 6'h0f
`define BTB_CARRY_BIT 0

`endif

// file: src/btb_pkg.sv
// Types shared by the bit-test/branch unit
package btb_pkg;
    typedef enum logic [2:0] {
        BTB_IDLE = 3'b000,
        BTB_EXEC = 3'b001,
        BTB_MEM_RD = 3'b010,
        BTB_MEM_WR = 3'b011,
        BTB_REG_RD = 3'b100,
        BTB_REG_WR = 3'b101
    } btb_state_e;

    typedef enum logic [3:0] {
        BTB_F_NONE = 4'b0000,
        BTB_F_EA = 4'b0001,
        BTB_F_ABS = 4'b0010,
        BTB_F_PP = 4'b0011,
        BTB_F_QQ = 4'b0100,
        BTB_F_REG = 4'b0101,
        BTB_F_BRA_LONG = 4'b0110,
        BTB_F_BRA_SHORT = 4'b0111,
        BTB_F_BRA_PTR = 4'b1000
    } btb_form_e;

    typedef struct packed {
        btb_form_e form;
        logic toggle;
        logic space;
        logic [4:0] bitn;
        logic [5:0] field;
        logic [2:0] ptr;
        logic [8:0] short_disp;
        logic illegal;
    } btb_dec_s;

    typedef struct packed {
        logic req;
        logic we;
        logic lock;
        logic space;
        logic [23:0] addr;
        logic [23:0] wdata;
    } btb_mem_s;

    typedef struct packed {
        logic sel;
        logic we;
        logic [5:0] idx;
        logic [23:0] wdata;
    } btb_reg_s;
endpackage : btb_pkg

// file: testbench/btb_core_tb.sv
// Self-checking bench for the bit-test and branch unit
`timescale 1ns/1ps
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
    mismatches++; $display("unexpected %s exp %h got %h", n, e, s); end end
module btb_core_tb import btb_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, stall = 1'b0, quiet = 1'b0, se, t, s;
    logic mem_ack, pready, pslverr;
    logic [7:0] paddr = 8'h00, op;
    logic [31:0] pwdata = 32'h0, prdata, rd, e, q[$];
    logic [23:0] mem_rdata, reg_rdata, pc, st, v, w, nw, ad, d, r;
    logic [23:0] bm [0:127];
    logic [5:0] ix [6] = '{6'h0e, 6'h0f, 6'h12, 6'h2b, 6'h39, 6'h39};
    logic [4:0] b;
    logic [1:0] md;
    btb_mem_s mem_cmd;
    btb_reg_s reg_cmd;
    integer seed = 73580, mismatches = 0, comparisons = 0;
    always #10 clk = ~clk;
    btb_core u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .mem_cmd(mem_cmd),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_cmd(reg_cmd),
        .reg_rdata(reg_rdata));
    btb_far_model u_far (.clk(clk), .stall(stall), .mem_cmd(mem_cmd),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .reg_cmd(reg_cmd),
        .reg_rdata(reg_rdata));
    always @(posedge clk) stall <= 1'($random(seed));
    // Results are compared in the order the driver noted them
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite && !quiet) chk(prdata);
        if (mem_ack && mem_cmd.we)
            chk({mem_cmd.addr[23], mem_cmd.addr[6], mem_cmd.space,
                mem_cmd.addr[4:0], mem_cmd.wdata});
        if (reg_cmd.we) chk({2'b00, reg_cmd.idx, reg_cmd.wdata});
    end
    task automatic chk(input logic [31:0] got);
        e = (q.size() != 0) ? q.pop_front() : 32'hxxxxxxxx;
        `CHK("result", e, got)
    endtask : chk
    task automatic tally_and_finish;
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic bust;
        mismatches++;
        tally_and_finish();
    endtask : bust
    task automatic apb(input logic wn, input logic [7:0] a,
        input logic [31:0] dt);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wn;
        paddr <= a;
        pwdata <= dt;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 9);
        rd = prdata;
        se = pslverr;
        if (pready !== 1'b1) bust();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [23:0] dt);
        apb(1'b1, a, {8'h00, dt});
    endtask : wr
    task automatic rx(input logic [7:0] a, input logic [23:0] ex);
        q.push_back({8'h00, ex});
        apb(1'b0, a, 32'h0);
    endtask : rx
    // Status polls are not checked, only waited on
    task automatic run(input logic [23:0] ins);
        int n;
        wr(8'h00, ins);
        quiet <= 1'b1;
        n = 0;
        do begin
            apb(1'b0, 8'h10, 32'h0);
            n++;
        end while (rd[0] !== 1'b0 && n < 40);
        quiet <= 1'b0;
        if (n >= 40) bust();
    endtask : run
    initial begin
        for (int i = 0; i < 128; i++)
            bm[i] = 24'h5a3c00 ^ (24'(i) * 24'h010203);
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        pc = 24'h0;
        rx(8'h08, 24'h0);
        rx(8'h0c, 24'h0);
        rx(8'h44, 24'h0);
        `CHK("slverr", 1'b1, se)
        for (int i = 0; i < 8; i++) begin
            v = 24'($random(seed));
            st = 24'($random(seed));
            t = i[2];
            s = v[6];
            b = (i == 0) ? 5'd23 : 5'(v[11:7] % 5'd24);
            op = {7'h05, t};
            md = 2'b00;
            ad = {18'h0, v[5:0]};
            case (i % 4)
                1: begin
                    md = 2'b10;
                    ad = {18'h3ffff, v[5:0]};
                end
                2: begin
                    op = 8'h01;
                    md = {1'b0, t};
                    ad = {17'h1ffff, 1'b0, v[5:0]};
                end
                3: begin
                    md = 2'b01;
                    ad = {17'h0, v[18:12]};
                    wr(8'h04, ad);
                end
            endcase
            w = bm[ad[6:0]];
            nw = t ? w ^ (24'h1 << b) : w & ~(24'h1 << b);
            bm[ad[6:0]] = nw;
            wr(8'h0c, st);
            q.push_back({ad[23], ad[6], s, ad[4:0], nw});
            run({op, md, (i % 4 == 3) ? 6'h30 : v[5:0], 1'b0, s, 1'b0, b});
            pc = pc + ((i % 4 == 3) ? 24'd2 : 24'd1);
            rx(8'h0c, {st[23:1], w[b]});
            rx(8'h08, pc);
        end
        run({8'h0a, 2'b00, 6'h05, 3'b000, 5'd24});
        rx(8'h10, 24'h2);
        foreach (ix[k]) begin
            v = 24'($random(seed));
            st = 24'($random(seed));
            b = (ix[k] != 6'h39) ? 5'(v[4:0] % 5'd24) : {1'b0, k[0], v[2:0]};
            r = {ix[k], ~ix[k], 12'h9c3};
            wr(8'h0c, st);
            if (ix[k] == 6'h39) begin
                st = st & ~(24'h1 << b);
            end else if (ix[k][5:1] != 5'h07) begin
                q.push_back({2'b00, ix[k], r & ~(24'h1 << b)});
                st = {st[23:1], r[b]};
            end
            run({8'h0a, 2'b11, ix[k], 3'b010, b});
            if (ix[k][5:1] == 5'h07) rx(8'h10, 24'h2);
            else pc = pc + 24'd1;
            rx(8'h0c, st);
            rx(8'h08, pc);
        end
        for (int k = 0; k < 6; k++) begin
            v = 24'($random(seed));
            st = 24'($random(seed));
            wr(8'h0c, st);
            d = v;
            if (k % 3 == 0) wr(8'h04, v);
            if (k % 3 == 1) d = {{15{v[8]}}, v[8:0]};
            if (k % 3 == 2) wr(8'h20 | {3'b000, v[2:0], 2'b00}, v);
            run((k % 3 == 0) ? 24'h0d10c0 : (k % 3 == 1) ?
                {14'h0143, v[8:5], 1'b0, v[4:0]} : {13'h01a3, v[2:0], 8'hc0});
            pc = pc + d;
            rx(8'h08, pc);
            rx(8'h0c, st);
        end
        tally_and_finish();
    end
endmodule : btb_core_tb

// file: testbench/btb_far_model.sv
// Data memory and register file facing the bit-test unit
`timescale 1ns/1ps
module btb_far_model import btb_pkg::*; (
    // Clock and stall control
    input wire logic clk,
    input wire logic stall,
    // Memory bus
    input wire btb_mem_s mem_cmd,
    output logic mem_ack,
    output logic [23:0] mem_rdata,
    // Register file
    input wire btb_reg_s reg_cmd,
    output logic [23:0] reg_rdata
);
    logic [23:0] mem [0:127];
    initial begin
        for (int i = 0; i < 128; i++)
            mem[i] = 24'h5a3c00 ^ (24'(i) * 24'h010203);
    end
    // Idle data lines show the inverse, never a stale word
    assign mem_rdata = mem[mem_cmd.addr[6:0]] ^ {24{~mem_ack}};
    assign reg_rdata = {reg_cmd.idx, ~reg_cmd.idx, 12'h9c3}
        ^ {24{~reg_cmd.sel}};
    // Random stalls give slow answers as well as prompt ones
    always @(posedge clk) begin
        mem_ack <= mem_cmd.req && !mem_ack && !stall;
        if (mem_ack && mem_cmd.we)
            mem[mem_cmd.addr[6:0]] <= mem_cmd.wdata;
    end
endmodule : btb_far_model
